/* File: design/rx_event_map.svh */
`ifndef RX_EVENT_MAP_SVH
`define RX_EVENT_MAP_SVH
`define A_LATCH4 8'h93
`define A_HDLC 8'h94
`define A_MAINT 8'h96
`define A_SIG0 8'h98
`define A_SPARE 8'h9C
`define A_MASK4 8'hA3
`define A_MASK5 8'hA4
`define A_MASK7 8'hA6
`define A_SIGEN0 8'hA8
`define A_SASEL 8'hAC
`define RESET_BYTE 8'h00
`define B_MF 0
`define B_SCOS 3
`define B_OVR 5
`define B_OPEN 4
`define B_PEND 3
`define B_PSTART 2
`define B_HWM 1
`define B_NE 0
`define B_RAICI 5
`define B_AISCI 4
`define B_SLC 3
`define B_DLF 2
`define B_BCLR 1
`define B_BDET 0
`define B_SA6 1
`define B_SAX 0
`define CLK_MHZ 100
`define MF_E1_TIME_US 2000
`define MF_E1_CYCLES (`MF_E1_TIME_US * `CLK_MHZ)
`endif

/* File: design/rx_event_pkg.sv */
package rx_event_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic overrun;
        logic open_next;
        logic packet_end;
        logic packet_start;
        logic above_wm;
        logic not_empty;
    } hdlc_ev_t;

    typedef struct packed {
        logic rai_ci;
        logic rai_active;
        logic ais_ci;
        logic ais_active;
        logic slc_align;
        logic dlink_full;
        logic code_clear;
        logic code_detect;
        logic sa6_code;
        logic [7:0] sa_bits;
    } maint_ev_t;

    typedef struct packed {
        logic e1;
        logic esf;
        logic cas;
        logic t1_mf;
        logic cas_mf;
    } frame_t;

    typedef struct packed {
        logic [7:0] latch4;
        logic [7:0] hdlc;
        logic [7:0] maint;
        logic [3:0][7:0] sig;
        logic [7:0] mask4;
        logic [7:0] mask5;
        logic [7:0] mask7;
        logic [3:0][7:0] sig_en;
        logic [7:0] sa_sel;
        logic [7:0] spare;
        logic spare_restart;
        logic [7:0] spare_care;
        logic wm_prev;
        logic ne_prev;
        logic [7:0] sa_prev;
        logic [17:0] mf_cnt;
        logic [7:0] rdata;
        logic irq_n;
    } state_t;
endpackage

/* File: design/rx_latched_event_status.sv */
`timescale 1ns/10ps
`include "rx_event_map.svh"
module rx_latched_event_status #(
    parameter int unsigned MF_E1_CYCLES = `MF_E1_CYCLES
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // host register port
    input rx_event_pkg::host_req_t host_i,
    output logic [7:0] rdata_o,
    output logic irq_out_n_o,
    // framer events
    input rx_event_pkg::frame_t frame_i,
    input rx_event_pkg::hdlc_ev_t hdlc_i,
    input rx_event_pkg::maint_ev_t maint_i,
    input wire logic [31:0] sig_change_i,
    input wire logic cas_align_change_i,
    input wire logic dist_mf_alarm_change_i,
    // spare-code detector
    input wire logic [3:0] spare_len_i,
    output logic [7:0] spare_pattern_o,
    output logic [7:0] spare_care_o,
    output logic spare_restart_o
);
    rx_event_pkg::state_t st_q;
    rx_event_pkg::state_t st_d;

    logic [7:0] hdlc_set;
    logic [7:0] maint_set;
    logic [7:0] l4_set;
    logic [3:0][7:0] sig_set;
    logic mf_wrap;
    logic mf_tick;
    logic rd_hit_l4;
    logic rd_hit_hdlc;
    logic rd_hit_maint;

    assign rd_hit_l4 = host_i.rd && host_i.addr == `A_LATCH4;
    assign rd_hit_hdlc = host_i.rd && host_i.addr == `A_HDLC;
    assign rd_hit_maint = host_i.rd && host_i.addr == `A_MAINT;
    assign mf_wrap = st_q.mf_cnt == 18'(MF_E1_CYCLES - 1);

    always_comb begin
        // free boundary keeps the host paced when CAS is off in E1 mode
        mf_tick = frame_i.t1_mf;
        if (frame_i.e1) begin
            mf_tick = frame_i.cas ? frame_i.cas_mf : mf_wrap;
        end
        if (frame_i.e1 && !frame_i.cas) begin
            mf_tick = mf_wrap;
        end
    end

    always_comb begin
        hdlc_set = 8'h00;
        hdlc_set[`B_OVR] = hdlc_i.overrun;
        hdlc_set[`B_OPEN] = hdlc_i.open_next;
        hdlc_set[`B_PEND] = hdlc_i.packet_end;
        hdlc_set[`B_PSTART] = hdlc_i.packet_start;
        // edge detects: level staying high does not re-arm
        hdlc_set[`B_HWM] = hdlc_i.above_wm && !st_q.wm_prev;
        hdlc_set[`B_NE] = hdlc_i.not_empty && !st_q.ne_prev;
    end

    always_comb begin
        maint_set = 8'h00;
        if (frame_i.e1) begin
            maint_set[`B_SA6] = maint_i.sa6_code;
            maint_set[`B_SAX] = |((maint_i.sa_bits ^ st_q.sa_prev)
                                  & st_q.sa_sel);
        end else begin
            maint_set[`B_RAICI] = maint_i.rai_ci && frame_i.esf
                                  && maint_i.rai_active;
            maint_set[`B_AISCI] = maint_i.ais_ci
                                  && maint_i.ais_active;
            maint_set[`B_SLC] = maint_i.slc_align;
            maint_set[`B_DLF] = maint_i.dlink_full;
            maint_set[`B_BCLR] = maint_i.code_clear;
            maint_set[`B_BDET] = maint_i.code_detect;
        end
    end

    always_comb begin
        sig_set = sig_change_i;
        if (!frame_i.e1) begin
            sig_set[3] = 8'h00;
        end
        if (frame_i.e1 && frame_i.cas) begin
            sig_set[0][0] = cas_align_change_i;
            sig_set[2][0] = dist_mf_alarm_change_i;
        end
        l4_set = 8'h00;
        l4_set[`B_MF] = mf_tick;
        l4_set[`B_SCOS] = |(sig_set & st_q.sig_en);
    end

    always_comb begin
        st_d = st_q;
        st_d.wm_prev = hdlc_i.above_wm;
        st_d.ne_prev = hdlc_i.not_empty;
        st_d.sa_prev = maint_i.sa_bits;
        st_d.mf_cnt = mf_wrap ? 18'h00000 : st_q.mf_cnt + 18'h00001;
        st_d.spare_restart = 1'b0;
        // set beats the read-clear so a same-cycle event survives
        st_d.latch4 = (st_q.latch4 & ~{8{rd_hit_l4}}) | l4_set;
        st_d.hdlc = (st_q.hdlc & ~{8{rd_hit_hdlc}}) | hdlc_set;
        st_d.maint = (st_q.maint & ~{8{rd_hit_maint}}) | maint_set;
        for (int i = 0; i < 4; i++) begin
            if (host_i.rd && host_i.addr == `A_SIG0 + 8'(i)) begin
                st_d.sig[i] = 8'h00;
            end
            st_d.sig[i] = st_d.sig[i] | sig_set[i];
        end
        st_d.rdata = 8'h00;
        if (host_i.rd) begin
            unique case (host_i.addr)
                `A_LATCH4: st_d.rdata = st_q.latch4;
                `A_HDLC: st_d.rdata = st_q.hdlc;
                `A_MAINT: st_d.rdata = st_q.maint;
                `A_SIG0: st_d.rdata = st_q.sig[0];
                `A_SIG0 + 8'h01: st_d.rdata = st_q.sig[1];
                `A_SIG0 + 8'h02: st_d.rdata = st_q.sig[2];
                `A_SIG0 + 8'h03: st_d.rdata = st_q.sig[3];
                `A_SPARE: st_d.rdata = st_q.spare;
                `A_MASK4: st_d.rdata = st_q.mask4;
                `A_MASK5: st_d.rdata = st_q.mask5;
                `A_MASK7: st_d.rdata = st_q.mask7;
                `A_SIGEN0: st_d.rdata = st_q.sig_en[0];
                `A_SIGEN0 + 8'h01: st_d.rdata = st_q.sig_en[1];
                `A_SIGEN0 + 8'h02: st_d.rdata = st_q.sig_en[2];
                `A_SIGEN0 + 8'h03: st_d.rdata = st_q.sig_en[3];
                `A_SASEL: st_d.rdata = st_q.sa_sel;
                default: st_d.rdata = 8'h00;
            endcase
        end
        if (host_i.wr) begin
            unique case (host_i.addr)
                `A_SPARE: begin
                    st_d.spare = host_i.wdata;
                    st_d.spare_restart = 1'b1;
                end
                `A_MASK4: st_d.mask4 = host_i.wdata;
                `A_MASK5: st_d.mask5 = host_i.wdata;
                `A_MASK7: st_d.mask7 = host_i.wdata;
                `A_SIGEN0: st_d.sig_en[0] = host_i.wdata;
                `A_SIGEN0 + 8'h01: st_d.sig_en[1] = host_i.wdata;
                `A_SIGEN0 + 8'h02: st_d.sig_en[2] = host_i.wdata;
                `A_SIGEN0 + 8'h03: st_d.sig_en[3] = host_i.wdata;
                `A_SASEL: st_d.sa_sel = host_i.wdata;
                default: st_d.sa_sel = st_q.sa_sel;
            endcase
        end
        // bit 7 is sent first; length 8 or more keeps every bit
        st_d.spare_care = ~(8'hFF >> spare_len_i);
        // irq follows the next latch state so it tracks the flops
        st_d.irq_n = ~|((st_d.latch4 & st_d.mask4)
                        | (st_d.hdlc & st_d.mask5)
                        | (st_d.maint & st_d.mask7));
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_q <= '0;
            st_q.irq_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o = st_q.rdata;
    assign irq_out_n_o = st_q.irq_n;
    assign spare_pattern_o = st_q.spare;
    assign spare_care_o = st_q.spare_care;
    assign spare_restart_o = st_q.spare_restart;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    property p_t1_mf;
        !frame_i.e1 && frame_i.t1_mf |=> st_q.latch4[`B_MF];
    endproperty
    a_t1_mf: assert property (p_t1_mf)
        else $error("t1 multiframe tick not latched");

    property p_e1_cas_mf;
        frame_i.e1 && frame_i.cas && frame_i.cas_mf
            |=> st_q.latch4[`B_MF];
    endproperty
    a_e1_cas_mf: assert property (p_e1_cas_mf)
        else $error("cas multiframe tick not latched");

    property p_free_mf;
        frame_i.e1 && !frame_i.cas && mf_wrap
            |=> st_q.latch4[`B_MF] && st_q.mf_cnt == 18'h00000;
    endproperty
    a_free_mf: assert property (p_free_mf)
        else $error("free multiframe boundary missed");

    property p_overrun;
        hdlc_i.overrun |=> st_q.hdlc[`B_OVR];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not latched");

    property p_pend_clear;
        rd_hit_hdlc && !hdlc_i.packet_end |=> !st_q.hdlc[`B_PEND];
    endproperty
    a_pend_clear: assert property (p_pend_clear)
        else $error("packet end not cleared by read");

    property p_set_wins;
        rd_hit_hdlc && hdlc_i.packet_start
            |=> st_q.hdlc[`B_PSTART]
            ##1 (st_q.hdlc[`B_PSTART] || $past(rd_hit_hdlc));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost during clearing read");

    property p_wm_edge;
        $rose(hdlc_i.above_wm) |=> st_q.hdlc[`B_HWM];
    endproperty
    a_wm_edge: assert property (p_wm_edge)
        else $error("watermark edge not latched");

    property p_ne_level;
        !rd_hit_hdlc ##1 (rd_hit_hdlc && $stable(hdlc_i.not_empty))
            |=> !st_q.hdlc[`B_NE];
    endproperty
    a_ne_level: assert property (p_ne_level)
        else $error("not-empty latched without an edge");

    property p_rai_gate;
        $rose(st_q.maint[`B_RAICI])
            |-> $past(frame_i.esf && maint_i.rai_active && !frame_i.e1);
    endproperty
    a_rai_gate: assert property (p_rai_gate)
        else $error("remote alarm ci latched outside esf alarm");

    property p_scos;
        |(sig_set & st_q.sig_en) |=> st_q.latch4[`B_SCOS];
    endproperty
    a_scos: assert property (p_scos)
        else $error("summary signaling change not set");

    property p_irq;
        |(st_q.hdlc & st_q.mask5) |-> !irq_out_n_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled event does not drive interrupt");

    property p_spare;
        host_i.wr && host_i.addr == `A_SPARE
            |=> spare_restart_o
            ##1 (!spare_restart_o
                || $past(host_i.wr && host_i.addr == `A_SPARE));
    endproperty
    a_spare: assert property (p_spare)
        else $error("spare write did not restart integration");

    property p_open_next;
        hdlc_i.open_next |=> st_q.hdlc[`B_OPEN];
    endproperty
    a_open_next: assert property (p_open_next)
        else $error("opening byte event not latched");

    property p_pend_set;
        hdlc_i.packet_end |=> st_q.hdlc[`B_PEND];
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("packet end not latched");

    property p_pstart;
        hdlc_i.packet_start |=> st_q.hdlc[`B_PSTART];
    endproperty
    a_pstart: assert property (p_pstart)
        else $error("packet start not latched");

    property p_ne_edge;
        $rose(hdlc_i.not_empty) |=> st_q.hdlc[`B_NE];
    endproperty
    a_ne_edge: assert property (p_ne_edge)
        else $error("not-empty edge not latched");

    property p_ais_gate;
        $rose(st_q.maint[`B_AISCI])
            |-> $past(maint_i.ais_active && !frame_i.e1);
    endproperty
    a_ais_gate: assert property (p_ais_gate)
        else $error("alarm indication ci latched without ais");

    property p_slc;
        !frame_i.e1 && maint_i.slc_align |=> st_q.maint[`B_SLC];
    endproperty
    a_slc: assert property (p_slc)
        else $error("loop-carrier alignment not latched");

    property p_dlf;
        !frame_i.e1 && maint_i.dlink_full |=> st_q.maint[`B_DLF];
    endproperty
    a_dlf: assert property (p_dlf)
        else $error("data link full not latched");

    property p_code_clear;
        !frame_i.e1 && maint_i.code_clear |=> st_q.maint[`B_BCLR];
    endproperty
    a_code_clear: assert property (p_code_clear)
        else $error("code clear not latched");

    property p_code_detect;
        !frame_i.e1 && maint_i.code_detect |=> st_q.maint[`B_BDET];
    endproperty
    a_code_detect: assert property (p_code_detect)
        else $error("code detect not latched");

    property p_sa6;
        frame_i.e1 && maint_i.sa6_code |=> st_q.maint[`B_SA6];
    endproperty
    a_sa6: assert property (p_sa6)
        else $error("sa6 codeword not latched");

    property p_sa_change;
        frame_i.e1
            && |((maint_i.sa_bits ^ $past(maint_i.sa_bits)) & st_q.sa_sel)
            |=> st_q.maint[`B_SAX];
    endproperty
    a_sa_change: assert property (p_sa_change)
        else $error("enabled sa bit change not latched");

    property p_sig_latch;
        !frame_i.e1 && sig_change_i[8] |=> st_q.sig[1][0];
    endproperty
    a_sig_latch: assert property (p_sig_latch)
        else $error("channel change not latched");

    property p_cas_align;
        frame_i.e1 && frame_i.cas && cas_align_change_i
            |=> st_q.sig[0][0];
    endproperty
    a_cas_align: assert property (p_cas_align)
        else $error("cas alignment change not latched");

    property p_care;
        spare_len_i == 4'h3 |=> spare_care_o == 8'hE0;
    endproperty
    a_care: assert property (p_care)
        else $error("spare care mask wrong for length three");

    property p_hdlc_irq;
        hdlc_i.overrun && st_q.mask5[`B_OVR] && !host_i.wr
            |=> !irq_out_n_o;
    endproperty
    a_hdlc_irq: assert property (p_hdlc_irq)
        else $error("unmasked hdlc event raised no interrupt");

    c_free_mf: cover property (frame_i.e1 && !frame_i.cas && mf_wrap);
    c_read_clear: cover property (rd_hit_hdlc && |st_q.hdlc);
    c_irq: cover property ($fell(irq_out_n_o));
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic mclk_i,
    // register port
    output rx_event_pkg::host_req_t host_o,
    input wire logic [7:0] rdata_i
);
    initial host_o = '0;

    // released address and data are inverted so stale values never match
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        host_o.wr <= 1'b1;
        host_o.addr <= a;
        host_o.wdata <= d;
        @(posedge mclk_i);
        host_o.wr <= 1'b0;
        host_o.addr <= ~a;
        host_o.wdata <= ~d;
    endtask

    // a read is the only way the host clears latched bits
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        host_o.rd <= 1'b1;
        host_o.addr <= a;
        @(posedge mclk_i);
        host_o.rd <= 1'b0;
        host_o.addr <= ~a;
        #1 d = rdata_i;
    endtask
endmodule

/* File: tb/rx_latched_event_status_tb_top.sv */
`timescale 1ns/10ps
module rx_latched_event_status_tb_top;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    rx_event_pkg::host_req_t host;
    rx_event_pkg::frame_t fr = '0;
    rx_event_pkg::hdlc_ev_t hd = '0;
    rx_event_pkg::maint_ev_t mt = '0;
    logic [31:0] sig = '0;
    logic cas_al = 1'b0;
    logic dma = 1'b0;
    logic [3:0] slen = 4'h8;
    logic [7:0] rdata, pat, care;
    logic irq_n, restart;
    int error_cnt = 0;
    int checks_done = 0;

    always #5 mclk_i = ~mclk_i;

    host_model u_host (.mclk_i(mclk_i), .host_o(host), .rdata_i(rdata));

    rx_latched_event_status #(.MF_E1_CYCLES(16)) DUT (
        .mclk_i(mclk_i), .srst_i(srst_i), .host_i(host), .rdata_o(rdata),
        .irq_out_n_o(irq_n), .frame_i(fr), .hdlc_i(hd), .maint_i(mt),
        .sig_change_i(sig), .cas_align_change_i(cas_al),
        .dist_mf_alarm_change_i(dma), .spare_len_i(slen),
        .spare_pattern_o(pat), .spare_care_o(care),
        .spare_restart_o(restart));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd_reg(a, d);
        chk(d, exp);
    endtask

    task automatic clr(input logic [7:0] a);
        logic [7:0] d;
        u_host.rd_reg(a, d);
    endtask

    task automatic t_reset();
        for (int a = 8'h93; a <= 8'h9C; a++) begin
            rchk(8'(a), 8'h00);
        end
        rchk(8'h90, 8'h00);
        chk({7'h00, irq_n}, 8'h01);
        $display("reset test done");
    endtask

    task automatic t_hdlc();
        for (int i = 2; i < 6; i++) begin
            @(posedge mclk_i) hd <= 6'(1 << i);
            @(posedge mclk_i) hd <= '0;
            rchk(8'h94, 8'(1 << i));
            rchk(8'h94, 8'h00);
        end
        @(posedge mclk_i) hd <= 6'h03;
        rchk(8'h94, 8'h03);
        rchk(8'h94, 8'h00);
        @(posedge mclk_i) hd <= '0;
        // event in the cycle of the clearing read survives
        fork
            clr(8'h94);
            begin
                @(posedge mclk_i) hd.overrun <= 1'b1;
                @(posedge mclk_i) hd.overrun <= 1'b0;
            end
        join
        rchk(8'h94, 8'h20);
        $display("hdlc test done");
    endtask

    task automatic t_irq();
        u_host.wr_reg(8'hA4, 8'h20);
        @(posedge mclk_i) hd.overrun <= 1'b1;
        @(posedge mclk_i) hd.overrun <= 1'b0;
        #1 chk({7'h00, irq_n}, 8'h00);
        rchk(8'h94, 8'h20);
        @(posedge mclk_i) #1 chk({7'h00, irq_n}, 8'h01);
        @(posedge mclk_i) hd.packet_end <= 1'b1;
        @(posedge mclk_i) hd.packet_end <= 1'b0;
        #1 chk({7'h00, irq_n}, 8'h01);
        rchk(8'h94, 8'h08);
        $display("irq test done");
    endtask

    task automatic t_maint();
        @(posedge mclk_i) fr <= 5'b01000;
        mt <= {1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 1'b0, 8'h00};
        @(posedge mclk_i) mt <= {1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 8'h00};
        rchk(8'h96, 8'h3F);
        @(posedge mclk_i) mt <= {1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 1'b0, 8'h00};
        @(posedge mclk_i) mt <= '0;
        rchk(8'h96, 8'h10);
        // remote alarm ci must stay quiet outside esf framing
        @(posedge mclk_i) fr <= 5'b00000;
        mt <= {1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 8'h00};
        @(posedge mclk_i) mt <= '0;
        rchk(8'h96, 8'h00);
        @(posedge mclk_i) fr <= 5'b10000;
        mt <= {8'h01, 1'b1, 8'h00};
        @(posedge mclk_i) mt <= '0;
        rchk(8'h96, 8'h02);
        u_host.wr_reg(8'hAC, 8'h01);
        @(posedge mclk_i) mt.sa_bits <= 8'h02;
        rchk(8'h96, 8'h00);
        @(posedge mclk_i) mt.sa_bits <= 8'h03;
        rchk(8'h96, 8'h01);
        $display("maint test done");
    endtask

    task automatic t_mf();
        @(posedge mclk_i) fr <= 5'b00000;
        clr(8'h93);
        @(posedge mclk_i) fr.t1_mf <= 1'b1;
        @(posedge mclk_i) fr.t1_mf <= 1'b0;
        rchk(8'h93, 8'h01);
        @(posedge mclk_i) fr <= 5'b10000;
        clr(8'h93);
        repeat (17) @(posedge mclk_i);
        rchk(8'h93, 8'h01);
        @(posedge mclk_i) fr <= 5'b10100;
        clr(8'h93);
        repeat (20) @(posedge mclk_i);
        rchk(8'h93, 8'h00);
        @(posedge mclk_i) fr.cas_mf <= 1'b1;
        @(posedge mclk_i) fr.cas_mf <= 1'b0;
        rchk(8'h93, 8'h01);
        $display("multiframe test done");
    endtask

    task automatic t_sig();
        @(posedge mclk_i) fr <= 5'b00000;
        u_host.wr_reg(8'hA8, 8'h01);
        u_host.wr_reg(8'hA3, 8'h08);
        @(posedge mclk_i) sig <= 32'h0100_0001;
        @(posedge mclk_i) sig <= '0;
        #1 chk({7'h00, irq_n}, 8'h00);
        rchk(8'h98, 8'h01);
        rchk(8'h9B, 8'h00);
        rchk(8'h93, 8'h08);
        @(posedge mclk_i) fr <= 5'b10100;
        sig <= 32'h8000_0000;
        cas_al <= 1'b1;
        dma <= 1'b1;
        @(posedge mclk_i) sig <= '0;
        cas_al <= 1'b0;
        dma <= 1'b0;
        rchk(8'h98, 8'h01);
        rchk(8'h9A, 8'h01);
        rchk(8'h9B, 8'h80);
        $display("signaling test done");
    endtask

    task automatic t_spare();
        @(posedge mclk_i) slen <= 4'h3;
        u_host.wr_reg(8'h9C, 8'hA5);
        #1 chk({7'h00, restart}, 8'h01);
        @(posedge mclk_i) #1 chk({7'h00, restart}, 8'h00);
        chk(pat, 8'hA5);
        chk(care, 8'hE0);
        rchk(8'h9C, 8'hA5);
        $display("spare test done");
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_reset();
        t_hdlc();
        t_irq();
        t_maint();
        t_mf();
        t_sig();
        t_spare();
        end_sim();
    end

    // whole run needs under two hundred cycles
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule
